// ==== design/mgmt_ctrl.sv ====
/*
  Management control and status logic of a pluggable module: 2-wire bus slave on the
  link clock, flag and interrupt logic, reset and low-power handling on the core clock.
  Assumes the link clock oversamples the bus clock at least eight times.
*/
// Contract
// - Each emphasis lane holds a 4-bit code, 0 to 7 meaning 0 to 7 dB; top bit set is reserved.
// - After power-on or release of the reset pin the module is fully functional within 2000 ms.
// - A low on the reset pin longer than 2 us resets the module; the host holds it that long.
// - The module answers bus transactions no later than 2000 ms after power-on.
// - Within 2000 ms of power-on the data-not-ready bit clears and the interrupt asserts.
// - A high on the low-power pin drops the module to low power within 100 us.
// - A flag condition sets its flag and pulls the interrupt low within 200 ms.
// - Flags clear on read and the interrupt releases within 500 us of that read.
// - Entering loss of signal sets its flag and asserts the interrupt within 100 ms.
// - Entering transmitter fault sets its flag and asserts the interrupt within 200 ms.
// - A set mask bit stops its flag driving the interrupt within 100 ms; clearing restores it.
// - After select goes low the module answers the bus within 100 us.
// - After select is released the module stops answering within 100 us.
// - Setting the power-down bit gives low power within 100 ms; clearing it restores in 300 ms.
// - Write-triggered response times count from the clock edge after the write's stop bit.
`timescale 1ns/1ps
module mgmt_ctrl #(
  parameter int unsigned INIT_CYCLES = mgmt_pkg::INIT_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        module_reset_low_in,
  input  wire logic        module_select_low_in,
  input  wire logic        low_power_pin,
  input  wire logic [3:0]  rx_los_in,
  input  wire logic [3:0]  tx_fault_in,
  output logic             interrupt_out_low,
  output logic             low_power_out,
  output logic             module_ready,
  output logic [15:0]      rx_emphasis
);
  import mgmt_pkg::*;

  link_state_t l_q, l_d;
  core_state_t c_q, c_d;

  // ****************************************
  // Link domain: 2-wire bus slave
  // ****************************************
  logic scl_rise, scl_fall, bus_start, bus_stop, acked;

  always_comb begin
    l_d = l_q;
    l_d.scl_s1 = scl_in;
    l_d.scl_s2 = l_q.scl_s1;
    l_d.scl_p  = l_q.scl_s2;
    l_d.sda_s1 = sda_in;
    l_d.sda_s2 = l_q.sda_s1;
    l_d.sda_p  = l_q.sda_s2;
    l_d.sel_s1 = module_select_low_in;
    l_d.sel_s2 = l_q.sel_s1;
    l_d.ack_s1 = c_q.ack_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    l_d.ack_seen = l_q.ack_s2;
    l_d.sda_o  = 1'b0;
    acked     = l_q.ack_s2 != l_q.ack_seen;
    scl_rise  = l_q.scl_s2 & ~l_q.scl_p;
    scl_fall  = ~l_q.scl_s2 & l_q.scl_p;
    bus_start = l_q.scl_s2 & l_q.scl_p & l_q.sda_p & ~l_q.sda_s2;
    bus_stop  = l_q.scl_s2 & l_q.scl_p & ~l_q.sda_p & l_q.sda_s2;
    if (l_q.sel_s2) begin
      // Deselected: drop any transfer and leave the line alone
      l_d.st     = L_IDLE;
      l_d.sda_oe = 1'b0;
    end else if (bus_start) begin
      l_d.st     = L_ADDR;
      l_d.bitcnt = 4'h0;
      l_d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      l_d.st     = L_IDLE;
      l_d.sda_oe = 1'b0;
    end else begin
      case (l_q.st)
        L_IDLE: begin
        end
        L_ADDR, L_WDATA: begin
          if (scl_rise) begin
            l_d.sh     = {l_q.sh[6:0], l_q.sda_s2};
            l_d.bitcnt = l_q.bitcnt + 4'h1;
          end else if (scl_fall && l_q.bitcnt == 4'h8) begin
            if (l_q.st == L_ADDR) begin
              if (l_q.sh[7:1] == DEV_ADDR) begin
                l_d.sda_oe = 1'b1;
                l_d.rw     = l_q.sh[0];
                l_d.st     = L_ACK_A;
              end else begin
                l_d.st = L_IDLE;
              end
            end else begin
              l_d.sda_oe = 1'b1;
              l_d.st     = L_ACK_W;
              if (l_q.first) begin
                l_d.ptr   = l_q.sh;
                l_d.first = 1'b0;
              end else begin
                // Write applied at once; no later than the stop bit
                l_d.rq     = '{write: 1'b1, addr: l_q.ptr, data: l_q.sh};
                l_d.rq_tgl = ~l_q.rq_tgl;
                l_d.ptr    = l_q.ptr + 8'h01;
              end
            end
          end
        end
        L_ACK_A: begin
          if (scl_fall) begin
            l_d.sda_oe = 1'b0;
            l_d.bitcnt = 4'h0;
            if (l_q.rw) begin
              l_d.rq     = '{write: 1'b0, addr: l_q.ptr, data: 8'h00};
              l_d.rq_tgl = ~l_q.rq_tgl;
              l_d.st     = L_FETCH;
            end else begin
              l_d.first = 1'b1;
              l_d.st    = L_WDATA;
            end
          end
        end
        L_ACK_W: begin
          if (scl_fall) begin
            l_d.sda_oe = 1'b0;
            l_d.bitcnt = 4'h0;
            l_d.st     = L_WDATA;
          end
        end
        L_FETCH: begin
          // Core answers within a few cycles, well inside the low phase of the bus clock
          if (acked) begin
            l_d.sh     = c_q.rdata;
            l_d.sda_oe = ~c_q.rdata[7];
            l_d.bitcnt = 4'h0;
            l_d.ptr    = l_q.ptr + 8'h01;
            l_d.st     = L_RDATA;
          end
        end
        L_RDATA: begin
          if (scl_fall) begin
            if (l_q.bitcnt == 4'h7) begin
              l_d.sda_oe = 1'b0;
              l_d.st     = L_MACK;
            end else begin
              l_d.sh     = {l_q.sh[6:0], 1'b0};
              l_d.sda_oe = ~l_q.sh[6];
              l_d.bitcnt = l_q.bitcnt + 4'h1;
            end
          end
        end
        L_MACK: begin
          if (scl_rise) begin
            l_d.more = ~l_q.sda_s2;
          end else if (scl_fall) begin
            if (l_q.more) begin
              l_d.rq     = '{write: 1'b0, addr: l_q.ptr, data: 8'h00};
              l_d.rq_tgl = ~l_q.rq_tgl;
              l_d.st     = L_FETCH;
            end else begin
              l_d.st = L_IDLE;
            end
          end
        end
        default: begin
          l_d.st     = L_IDLE;
          l_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      l_q        <= '0;
      l_q.scl_s1 <= 1'b1;
      l_q.scl_s2 <= 1'b1;
      l_q.scl_p  <= 1'b1;
      l_q.sda_s1 <= 1'b1;
      l_q.sda_s2 <= 1'b1;
      l_q.sda_p  <= 1'b1;
      l_q.sel_s1 <= 1'b1;
      l_q.sel_s2 <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************
  // Core domain: reset, flags, registers
  // ****************************************
  logic       soft_rst;
  logic [3:0] los_new, flt_new, los_clr, flt_clr;
  logic       init_clr;
  bus_req_t   rq;

  always_comb begin
    c_d = c_q;
    c_d.rl_s1  = module_reset_low_in;
    c_d.rl_s2  = c_q.rl_s1;
    c_d.lp_s1  = low_power_pin;
    c_d.lp_s2  = c_q.lp_s1;
    c_d.los_s1 = rx_los_in;
    c_d.los_s2 = c_q.los_s1;
    c_d.los_p  = c_q.los_s2;
    c_d.flt_s1 = tx_fault_in;
    c_d.flt_s2 = c_q.flt_s1;
    c_d.flt_p  = c_q.flt_s2;
    c_d.rq_s1  = l_q.rq_tgl;
    c_d.rq_s2  = c_q.rq_s1;
    rq       = l_q.rq;
    los_new  = c_q.los_s2 & ~c_q.los_p;
    flt_new  = c_q.flt_s2 & ~c_q.flt_p;
    los_clr  = 4'h0;
    flt_clr  = 4'h0;
    init_clr = 1'b0;
    // Pulse filter: shorter lows are glitches
    if (c_q.rl_s2) begin
      c_d.rl_cnt = 6'h00;
    end else if (c_q.rl_cnt != RESET_MIN_CYCLES) begin
      c_d.rl_cnt = c_q.rl_cnt + 6'h01;
    end
    soft_rst = ~c_q.rl_s2 && c_q.rl_cnt == RESET_MIN_CYCLES;
    // Bus request from the link side; payload is stable once the toggle arrives
    if (c_q.rq_s2 != c_q.rq_seen) begin
      c_d.rq_seen = c_q.rq_s2;
      c_d.ack_tgl = ~c_q.ack_tgl;
      if (rq.write) begin
        case (rq.addr)
          LOS_MASK_OFS:   c_d.los_mask = rq.data[3:0];
          FAULT_MASK_OFS: c_d.flt_mask = rq.data[3:0];
          PDOWN_OFS:      c_d.pdown = rq.data[PDOWN_BIT];
          EMPH_HI_OFS: begin
            // Reserved codes are refused per lane; the lane keeps its old code
            if (!rq.data[4 + EMPH_RSVD_BIT]) c_d.emph[15:12] = rq.data[7:4];
            if (!rq.data[EMPH_RSVD_BIT]) c_d.emph[11:8] = rq.data[3:0];
          end
          EMPH_LO_OFS: begin
            if (!rq.data[4 + EMPH_RSVD_BIT]) c_d.emph[7:4] = rq.data[7:4];
            if (!rq.data[EMPH_RSVD_BIT]) c_d.emph[3:0] = rq.data[3:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (rq.addr)
          STATUS_OFS: begin
            c_d.rdata = 8'h00;
            c_d.rdata[NOT_READY_BIT] = c_q.not_ready;
            init_clr = 1'b1;
          end
          LOS_FLAG_OFS: begin
            c_d.rdata = {4'h0, c_q.los_flag};
            los_clr = 4'hF;
          end
          FAULT_FLAG_OFS: begin
            c_d.rdata = {4'h0, c_q.flt_flag};
            flt_clr = 4'hF;
          end
          LOS_MASK_OFS:   c_d.rdata = {4'h0, c_q.los_mask};
          FAULT_MASK_OFS: c_d.rdata = {4'h0, c_q.flt_mask};
          PDOWN_OFS: begin
            c_d.rdata = 8'h00;
            c_d.rdata[PDOWN_BIT] = c_q.pdown;
          end
          EMPH_HI_OFS:    c_d.rdata = c_q.emph[15:8];
          EMPH_LO_OFS:    c_d.rdata = c_q.emph[7:0];
          default:        c_d.rdata = 8'h00;
        endcase
      end
    end
    // A new event in the cycle of its read-clear survives
    c_d.los_flag  = (c_q.los_flag & ~los_clr) | los_new;
    c_d.flt_flag  = (c_q.flt_flag & ~flt_clr) | flt_new;
    c_d.init_flag = c_q.init_flag & ~init_clr;
    if (c_q.not_ready) begin
      if (c_q.init_cnt == 26'(INIT_CYCLES - 1)) begin
        c_d.not_ready = 1'b0;
        c_d.init_flag = 1'b1;
      end else begin
        c_d.init_cnt = c_q.init_cnt + 26'h1;
      end
    end
    if (soft_rst) begin
      c_d.not_ready = 1'b1;
      c_d.init_cnt  = 26'h0;
      c_d.init_flag = 1'b0;
      c_d.los_flag  = 4'h0;
      c_d.flt_flag  = 4'h0;
      c_d.los_mask  = 4'h0;
      c_d.flt_mask  = 4'h0;
      c_d.pdown     = 1'b0;
      c_d.emph      = EMPH_RESET;
    end
    c_d.int_low = ~(c_d.init_flag | |(c_d.los_flag & ~c_d.los_mask)
                  | |(c_d.flt_flag & ~c_d.flt_mask));
    c_d.lp_out  = c_q.lp_s2 | c_d.pdown | c_d.not_ready;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      c_q           <= '0;
      c_q.rl_s1     <= 1'b1;
      c_q.rl_s2     <= 1'b1;
      c_q.not_ready <= 1'b1;
      c_q.int_low   <= 1'b1;
      c_q.lp_out    <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  assign sda_out           = l_q.sda_o;
  assign sda_oe            = l_q.sda_oe;
  assign interrupt_out_low = c_q.int_low;
  assign low_power_out     = c_q.lp_out;
  assign module_ready      = ~c_q.not_ready;
  assign rx_emphasis       = c_q.emph;

endmodule

// ==== design/mgmt_pkg.sv ====
/*
  Shared constants and carrier types of the management control and status block.
  Assumes a 25 MHz core clock and a slow 2-wire bus oversampled on the link clock.
*/
package mgmt_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_KHZ            = 25000;
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned INIT_MS            = 2000;
  localparam int unsigned INIT_CYCLES_DEF    = INIT_MS * CLK_KHZ;
  localparam int unsigned RESET_MIN_NS       = 2000;
  localparam logic [5:0]  RESET_MIN_CYCLES   =
    6'((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned LP_ASSERT_US       = 100;
  localparam int unsigned SELECT_US          = 100;

  // ****************************************
  // Bus address and register map
  // ****************************************
  localparam logic [6:0] DEV_ADDR            = 7'h50;
  localparam logic [7:0] STATUS_OFS          = 8'h02;
  localparam int unsigned NOT_READY_BIT      = 0;
  localparam logic [7:0] LOS_FLAG_OFS        = 8'h03;
  localparam logic [7:0] FAULT_FLAG_OFS      = 8'h04;
  localparam logic [7:0] PDOWN_OFS           = 8'h5D;
  localparam int unsigned PDOWN_BIT          = 0;
  localparam logic [7:0] LOS_MASK_OFS        = 8'h64;
  localparam logic [7:0] FAULT_MASK_OFS      = 8'h65;
  localparam logic [7:0] EMPH_HI_OFS         = 8'hEC;
  localparam logic [7:0] EMPH_LO_OFS         = 8'hED;
  localparam logic [15:0] EMPH_RESET         = 16'h0000;
  localparam int unsigned EMPH_RSVD_BIT      = 3;

  // ****************************************
  // Carriers and state
  // ****************************************
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } bus_req_t;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_ADDR  = 3'b001,
    L_ACK_A = 3'b011,
    L_WDATA = 3'b010,
    L_ACK_W = 3'b110,
    L_FETCH = 3'b111,
    L_RDATA = 3'b101,
    L_MACK  = 3'b100
  } link_st_t;

  typedef struct packed {
    logic     scl_s1, scl_s2, scl_p;
    logic     sda_s1, sda_s2, sda_p;
    logic     sel_s1, sel_s2;
    logic     ack_s1, ack_s2, ack_seen;
    link_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic     rw;
    logic     first;
    logic     more;
    logic     sda_oe;
    logic     sda_o;
    logic     rq_tgl;
    bus_req_t rq;
  } link_state_t;

  typedef struct packed {
    logic        rl_s1, rl_s2;
    logic [5:0]  rl_cnt;
    logic        lp_s1, lp_s2;
    logic [3:0]  los_s1, los_s2, los_p;
    logic [3:0]  flt_s1, flt_s2, flt_p;
    logic        rq_s1, rq_s2, rq_seen;
    logic        ack_tgl;
    logic [7:0]  rdata;
    logic        not_ready;
    logic [25:0] init_cnt;
    logic        init_flag;
    logic [3:0]  los_flag, flt_flag;
    logic [3:0]  los_mask, flt_mask;
    logic        pdown;
    logic [15:0] emph;
    logic        int_low;
    logic        lp_out;
  } core_state_t;

endpackage

// ==== test/mgmt_ctrl_properties.sv ====
/*
  Concurrent checks on the ports of the management block, bound into each instance.
  Assumes rst clears both clock domains and INIT_CYCLES matches the instance.
*/
`timescale 1ns/1ps
module mgmt_ctrl_properties #(
  parameter int unsigned INIT_CYCLES = 200
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        link_clk,
  input wire logic        module_reset_low_in,
  input wire logic        module_select_low_in,
  input wire logic        low_power_pin,
  input wire logic        sda_oe,
  input wire logic        interrupt_out_low,
  input wire logic        low_power_out,
  input wire logic        module_ready,
  input wire logic [15:0] rx_emphasis
);
  // ****************************************
  // Helper counters and sequences
  // ****************************************
  logic [31:0] wait_q;
  logic [5:0]  low_q;
  // Restarts on the raw pin; the design syncs it first, so its own wait runs a little longer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 32'h0;
      low_q  <= 6'h00;
    end else begin
      wait_q <= (module_ready || !module_reset_low_in) ? 32'h0 : wait_q + 32'h1;
      low_q  <= module_reset_low_in ? 6'h00 : (low_q == 6'h3F) ? low_q : low_q + 6'h01;
    end
  end
  sequence ready_rise_s;
    $rose(module_ready);
  endsequence
  sequence irq_low_s;
    ##[0:2] !interrupt_out_low;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  ready_late_a: assert property (@(posedge clock) disable iff (rst)
    wait_q <= INIT_CYCLES + 12) else $error("ready came too late");
  ready_early_a: assert property (@(posedge clock) disable iff (rst)
    ready_rise_s |-> wait_q >= INIT_CYCLES - 1) else $error("ready came too early");
  ready_irq_a: assert property (@(posedge clock) disable iff (rst)
    ready_rise_s |-> irq_low_s) else $error("no interrupt at ready");
  reset_pulse_a: assert property (@(posedge clock) disable iff (rst)
    low_q >= 6'h3A |-> !module_ready) else $error("long reset pulse ignored");
  notready_lp_a: assert property (@(posedge clock) disable iff (rst)
    !module_ready [*3] |-> low_power_out) else $error("full power while not ready");
  lp_pin_a: assert property (@(posedge clock) disable iff (rst)
    low_power_pin [*6] |-> low_power_out) else $error("low power pin not obeyed");
  emph_rsvd_a: assert property (@(posedge clock) disable iff (rst)
    !(rx_emphasis[15] || rx_emphasis[11] || rx_emphasis[7] || rx_emphasis[3]))
    else $error("reserved emphasis code applied");
  desel_quiet_a: assert property (@(posedge link_clk) disable iff (rst)
    module_select_low_in [*5] |-> !sda_oe) else $error("bus driven while deselected");
endmodule

bind mgmt_ctrl mgmt_ctrl_properties #(.INIT_CYCLES(INIT_CYCLES)) u_props (
  .clock(clock), .rst(rst), .link_clk(link_clk), .module_reset_low_in(module_reset_low_in),
  .module_select_low_in(module_select_low_in), .low_power_pin(low_power_pin),
  .sda_oe(sda_oe), .interrupt_out_low(interrupt_out_low), .low_power_out(low_power_out),
  .module_ready(module_ready), .rx_emphasis(rx_emphasis)
);

// ==== test/mgmt_host.sv ====
/*
  Host side of the 2-wire management bus: start, stop and byte transfer tasks.
  Assumes an open-drain wire with pull-up resolved by the bench from sda_pull.
*/
`timescale 1ns/1ps
module mgmt_host (
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_pull
);
  // Two ticks of SCL low keep the low phase at 2 us, above the slave's 1.5 us need
  localparam int unsigned HALF = 25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(posedge clock);
    #2;
  endtask
  // Also a repeated start; SDA only moves while SCL is low or as start/stop
  task automatic start();
    tick(); sda_pull = 1'b0; tick(); scl = 1'b1; tick(); sda_pull = 1'b1; tick(); scl = 1'b0;
  endtask
  task automatic stop();
    tick(); sda_pull = 1'b1; tick(); scl = 1'b1; tick(); sda_pull = 1'b0; tick();
  endtask
  task automatic bit_io(input logic b, output logic s);
    tick(); sda_pull = !b; tick(); scl = 1'b1; tick(); s = sda_wire; scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask
endmodule

// ==== test/tb_mgmt_ctrl.sv ====
/*
  Self-checking bench of the management block driven through the host bus model.
  Assumes the checker is bound to the design and the core clock runs at 25 MHz.
*/
`timescale 1ns/1ps
module tb_mgmt_ctrl;
  import mgmt_pkg::*;
  localparam int unsigned INIT = 200;
  logic        clock, rst, link_clk, scl, sda_pull, sda_out, sda_oe;
  logic        mod_rst_low, sel_low, lp_pin, irq_low, lp_out, ready, ack;
  logic [3:0]  los, flt;
  logic [15:0] emph;
  logic [7:0]  rd;
  int          fails, n_tests;
  wire         sda_wire = !(sda_oe && !sda_out) && !sda_pull;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end
  mgmt_ctrl #(.INIT_CYCLES(INIT)) u_dut (
    .clock(clock), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .module_reset_low_in(mod_rst_low),
    .module_select_low_in(sel_low), .low_power_pin(lp_pin), .rx_los_in(los),
    .tx_fault_in(flt), .interrupt_out_low(irq_low), .low_power_out(lp_out),
    .module_ready(ready), .rx_emphasis(emph)
  );
  mgmt_host u_host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bit_is(input string n, input logic e, input logic g);
    check(n, 16'(e), 16'(g));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    u_host.start();
    u_host.xfer({DEV_ADDR, 1'b0}, 1'b1, rd, ack);
    u_host.xfer(a, 1'b1, rd, ack);
    u_host.xfer(d, 1'b1, rd, ack);
    u_host.stop();
    bit_is("write ack", 1'b0, ack);
  endtask
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
    u_host.start();
    u_host.xfer({DEV_ADDR, 1'b0}, 1'b1, rd, ack);
    u_host.xfer(a, 1'b1, rd, ack);
    u_host.start();
    u_host.xfer({DEV_ADDR, 1'b1}, 1'b1, rd, ack);
    u_host.xfer(8'hFF, 1'b1, rd, ack);
    u_host.stop();
    check(n, 16'(e), 16'(rd));
  endtask
  task automatic wait_ready();
    for (int i = 0; i < INIT + 20 && ready !== 1'b1; i++) cyc(1);
    bit_is("ready", 1'b1, ready);
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    cyc(80000);
    fails++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    mod_rst_low = 1'b1;
    sel_low = 1'b0;
    lp_pin = 1'b0;
    los = 4'h0;
    flt = 4'h0;
    fails = 0;
    n_tests = 0;
    cyc(12);
    bit_is("ready in reset", 1'b0, ready);
    rst = 1'b0;
    wait_ready();
    cyc(2);
    bit_is("init irq", 1'b0, irq_low);
    chk_rd("status", STATUS_OFS, 8'h00);
    bit_is("sda drive", 1'b0, sda_out);
    cyc(10);
    bit_is("irq after status", 1'b1, irq_low);
    los = 4'h2;
    cyc(10);
    bit_is("los irq", 1'b0, irq_low);
    chk_rd("los flag", LOS_FLAG_OFS, 8'h02);
    cyc(10);
    bit_is("los irq clear", 1'b1, irq_low);
    chk_rd("los cleared", LOS_FLAG_OFS, 8'h00);
    wreg(FAULT_MASK_OFS, 8'h0F);
    chk_rd("mask", FAULT_MASK_OFS, 8'h0F);
    flt = 4'h4;
    cyc(10);
    bit_is("masked irq", 1'b1, irq_low);
    chk_rd("fault latched", FAULT_FLAG_OFS, 8'h04);
    wreg(FAULT_MASK_OFS, 8'h00);
    flt = 4'h5;
    los = 4'h6;
    cyc(10);
    bit_is("fault irq", 1'b0, irq_low);
    chk_rd("fault flag", FAULT_FLAG_OFS, 8'h01);
    cyc(10);
    bit_is("irq held", 1'b0, irq_low);
    chk_rd("los flag 2", LOS_FLAG_OFS, 8'h04);
    cyc(10);
    bit_is("irq released", 1'b1, irq_low);
    wreg(LOS_MASK_OFS, 8'h08);
    chk_rd("los mask", LOS_MASK_OFS, 8'h08);
    los = 4'hE;
    cyc(10);
    bit_is("los masked", 1'b1, irq_low);
    chk_rd("los masked flag", LOS_FLAG_OFS, 8'h08);
    wreg(8'h10, 8'hA5);
    chk_rd("unmapped", 8'h10, 8'h00);
    for (int k = 0; k < 8; k += 2) begin
      wreg(EMPH_HI_OFS, 8'(k * 17 + 1));
      check("emph hi", 16'(8'(k * 17 + 1)), 16'(emph[15:8]));
    end
    wreg(EMPH_LO_OFS, 8'h95);
    wreg(EMPH_LO_OFS, 8'h3F);
    check("emph", 16'h6735, emph);
    // Two-byte read; master ACK after the first byte walks the pointer on
    u_host.start();
    u_host.xfer({DEV_ADDR, 1'b0}, 1'b1, rd, ack);
    u_host.xfer(EMPH_HI_OFS, 1'b1, rd, ack);
    u_host.start();
    u_host.xfer({DEV_ADDR, 1'b1}, 1'b1, rd, ack);
    u_host.xfer(8'hFF, 1'b0, rd, ack);
    check("burst hi", 16'h0067, 16'(rd));
    u_host.xfer(8'hFF, 1'b1, rd, ack);
    u_host.stop();
    check("burst lo", 16'h0035, 16'(rd));
    wreg(PDOWN_OFS, 8'h01);
    cyc(8);
    bit_is("pdown on", 1'b1, lp_out);
    wreg(PDOWN_OFS, 8'h00);
    cyc(8);
    bit_is("pdown off", 1'b0, lp_out);
    lp_pin = 1'b1;
    cyc(8);
    bit_is("pin low power", 1'b1, lp_out);
    lp_pin = 1'b0;
    sel_low = 1'b1;
    cyc(10);
    u_host.start();
    u_host.xfer({DEV_ADDR, 1'b0}, 1'b1, rd, ack);
    u_host.stop();
    bit_is("deselected ack", 1'b1, ack);
    sel_low = 1'b0;
    cyc(10);
    chk_rd("selected", PDOWN_OFS, 8'h00);
    mod_rst_low = 1'b0;
    cyc(20);
    mod_rst_low = 1'b1;
    cyc(10);
    bit_is("short pulse", 1'b1, ready);
    mod_rst_low = 1'b0;
    cyc(80);
    bit_is("soft reset", 1'b0, ready);
    check("emph cleared", 16'h0000, emph);
    mod_rst_low = 1'b1;
    wait_ready();
    end_sim();
  end
endmodule
